// ===== hw/osps_regs.vh
// constants for the operand access phase scheduler
`ifndef OSPS_REGS_VH
`define OSPS_REGS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define OSPS_CLK_NS 10
`define OSPS_CYCLE_NS 60
`define OSPS_PHASE_NS 30
`define OSPS_PHASE_CYC ((`OSPS_PHASE_NS + `OSPS_CLK_NS - 1) / `OSPS_CLK_NS)

// ----------------------------------------------------------------
// opcode top bits (bits 31..29)
// ----------------------------------------------------------------
`define OSPS_OP_TRI 3'h1
`define OSPS_OP_TWO_A 3'h0
`define OSPS_OP_TWO_B 3'h2
`define OSPS_TOP_PST 2'h3
`define OSPS_TOP_PMA 2'h2
`define OSPS_TOP_HI 2
`define OSPS_TOP_LO 1

// ----------------------------------------------------------------
// instruction classes
// ----------------------------------------------------------------
`define OSPS_CLS_NONE 3'h0
`define OSPS_CLS_TWO 3'h1
`define OSPS_CLS_TRI 3'h2
`define OSPS_CLS_PST 3'h3
`define OSPS_CLS_PDS 3'h4
`define OSPS_CLS_PMA 3'h5

// ----------------------------------------------------------------
// scheduler states
// ----------------------------------------------------------------
`define OSPS_S_IDLE 3'h0
`define OSPS_S_EXEC1 3'h1
`define OSPS_S_EXEC2 3'h2
`define OSPS_S_WAITBUS 3'h3
`define OSPS_S_DUMMY1 3'h4
`define OSPS_S_DUMMY2 3'h5

// ----------------------------------------------------------------
// external store bus cycle counts
// ----------------------------------------------------------------
`define OSPS_ST_NONE 3'h0
`define OSPS_ST_ONE 3'h2
`define OSPS_ST_TWO 3'h4
`define OSPS_ST_HALF 3'h2
`define OSPS_SEL_FIRST 1'b0
`define OSPS_SEL_SECOND 1'b1

`endif

// ===== hw/osps_phase_gen.v
// minor phase generator: splits each machine cycle into early and late phase
`timescale 1ns/1ps
module osps_phase_gen
#(
   parameter PHASE_CYC = 3
)
(
   input wire clk,          // core clock
   input wire rst_n,        // async reset, active low
   output wire early_phase, // first minor phase active
   output wire late_phase,  // second minor phase active
   output wire early_start, // first clock of early phase
   output wire late_end     // last clock of late phase
);
   localparam integer PH_I = PHASE_CYC;
   localparam integer LAST_I = 2 * PHASE_CYC - 1;
   localparam [7:0] PH = PH_I[7:0];
   localparam [7:0] LAST = LAST_I[7:0];

   reg [7:0] cnt;

   // ----------------------------------------------------------------
   // phase counter
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= 8'h00;
      else if (cnt == LAST)
         cnt <= 8'h00;
      else
         cnt <= cnt + 8'h01;
   end

   assign early_phase = (cnt < PH);
   assign late_phase = ~early_phase;
   assign early_start = (cnt == 8'h00);
   assign late_end = (cnt == LAST);
endmodule

// ===== hw/osps_operand_phase_sched.v
// operand access phase scheduler: places operand reads and stores in minor phases
`timescale 1ns/1ps
`include "osps_regs.vh"
module osps_operand_phase_sched
#(
   parameter PHASE_CYC = `OSPS_PHASE_CYC
)
(
   input wire clk,                 // core clock
   input wire rst_n,               // async reset, active low
   input wire in_valid,            // read stage offers an instruction
   input wire [2:0] in_op_top,     // opcode bits 31..29
   input wire in_dual_store,       // within class 11: two parallel stores
   input wire in_store,            // two-operand: access is a store
   input wire in_a_mem,            // first operand/destination is memory
   input wire in_a_ext,            // first operand/destination is external
   input wire in_b_mem,            // second operand/destination is memory
   input wire in_b_ext,            // second operand/destination is external
   output wire in_ready,           // instruction taken at late phase end
   output wire pipe_hold,          // hold stages behind current instruction
   output wire op_done,            // last access of instruction latched
   output wire early_phase,        // early minor phase active
   output wire late_phase,         // late minor phase active
   output wire int_rd_en,          // internal read this phase
   output wire int_rd_sel,         // 0 first/third, 1 second/fourth
   output wire int_wr_en,          // internal store this phase
   output wire int_wr_sel,         // 0 first dest, 1 second dest
   output wire ext_rd_en,          // external read bus cycle
   output wire ext_rd_sel,         // operand being read externally
   output wire ext_rd_dummy,       // external read is a dummy read
   output wire ext_rd_latch,       // latch external read data
   output wire ext_wr_en,          // external store bus cycle
   output wire ext_wr_sel,         // destination being stored
   output wire ext_post,           // value posted to port
   output wire primary_bus_strobe  // external bus cycle active
);
   // ----------------------------------------------------------------
   // phase generation
   // ----------------------------------------------------------------
   wire early_start;
   wire late_end;

   osps_phase_gen #(.PHASE_CYC(PHASE_CYC)) u_phase
   (
      .clk(clk),
      .rst_n(rst_n),
      .early_phase(early_phase),
      .late_phase(late_phase),
      .early_start(early_start),
      .late_end(late_end)
   );

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg [2:0] state;
   reg [2:0] next_state;
   reg [2:0] q_cls;
   reg q_store;
   reg q_a_mem;
   reg q_a_ext;
   reg q_b_mem;
   reg q_b_ext;
   reg [2:0] st_cnt;
   reg st_sel;
   reg st_gap;
   reg st_two;
   reg last_single;

   // ----------------------------------------------------------------
   // decode of offered instruction
   // ----------------------------------------------------------------
   reg [2:0] in_cls;

   always @*
   begin
      in_cls = `OSPS_CLS_NONE;
      if (in_op_top[`OSPS_TOP_HI:`OSPS_TOP_LO] == `OSPS_TOP_PST)
         in_cls = in_dual_store ? `OSPS_CLS_PDS : `OSPS_CLS_PST;
      else if (in_op_top[`OSPS_TOP_HI:`OSPS_TOP_LO] == `OSPS_TOP_PMA)
         in_cls = `OSPS_CLS_PMA;
      else if (in_op_top == `OSPS_OP_TRI)
         in_cls = `OSPS_CLS_TRI;
      else if (in_op_top == `OSPS_OP_TWO_A || in_op_top == `OSPS_OP_TWO_B)
         in_cls = `OSPS_CLS_TWO;
   end

   wire take = late_end && in_ready && in_valid;
   wire [2:0] d_cls = take ? in_cls : q_cls;
   wire d_store = take ? in_store : q_store;
   wire d_a_mem = take ? (in_a_mem || in_cls == `OSPS_CLS_PMA) : q_a_mem;
   wire d_a_ext = take ? in_a_ext : q_a_ext;
   wire d_b_mem = take ? (in_b_mem || in_cls == `OSPS_CLS_PMA) : q_b_mem;
   wire d_b_ext = take ? in_b_ext : q_b_ext;
   wire d_ax = d_a_mem && d_a_ext;
   wire d_bx = d_b_mem && d_b_ext;
   wire d_need_bus = d_ax || d_bx;
   wire d_dummy = (d_cls == `OSPS_CLS_TRI) && d_bx && last_single;
   wire d_single = ((d_cls == `OSPS_CLS_TWO) && d_store && d_ax)
                   || ((d_cls == `OSPS_CLS_PST) && d_bx);

   // store engine load values for the offered instruction
   reg [2:0] d_st_cnt;
   reg d_st_sel;
   reg d_st_gap;
   reg d_st_two;

   always @*
   begin
      d_st_cnt = `OSPS_ST_NONE;
      d_st_sel = `OSPS_SEL_FIRST;
      d_st_gap = 1'b0;
      d_st_two = 1'b0;
      case (d_cls)
         `OSPS_CLS_TWO:
         begin
            if (d_store && d_ax)
               d_st_cnt = `OSPS_ST_ONE;
         end
         `OSPS_CLS_PST:
         begin
            if (d_bx)
            begin
               d_st_cnt = `OSPS_ST_ONE;
               d_st_sel = `OSPS_SEL_SECOND;
               d_st_gap = d_ax;
            end
         end
         `OSPS_CLS_PDS:
         begin
            if (d_ax && d_bx)
            begin
               d_st_cnt = `OSPS_ST_TWO;
               d_st_two = 1'b1;
            end
            else if (d_ax)
               d_st_cnt = `OSPS_ST_ONE;
            else if (d_bx)
            begin
               d_st_cnt = `OSPS_ST_ONE;
               d_st_sel = `OSPS_SEL_SECOND;
               d_st_gap = 1'b1;
            end
         end
         default:
         begin
            d_st_cnt = `OSPS_ST_NONE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   wire q_pair = (q_cls == `OSPS_CLS_TRI || q_cls == `OSPS_CLS_PMA) && q_a_mem && q_b_mem;
   wire two_cycle = q_pair && q_a_ext;
   wire [2:0] st_rem = st_gap ? st_cnt : ((st_cnt == `OSPS_ST_NONE) ? st_cnt : st_cnt - 3'h1);
   wire bus_free = (st_rem == `OSPS_ST_NONE);

   assign in_ready = (state == `OSPS_S_IDLE) || (state == `OSPS_S_EXEC2)
                     || ((state == `OSPS_S_EXEC1) && !two_cycle);
   assign pipe_hold = (state != `OSPS_S_IDLE) && !in_ready;
   assign op_done = late_end && ((state == `OSPS_S_EXEC2)
                    || ((state == `OSPS_S_EXEC1) && !two_cycle));

   always @*
   begin
      next_state = state;
      if (take)
      begin
         if (d_need_bus && !bus_free)
            next_state = `OSPS_S_WAITBUS;
         else if (d_dummy)
            next_state = `OSPS_S_DUMMY1;
         else
            next_state = `OSPS_S_EXEC1;
      end
      else if (late_end)
      begin
         case (state)
            `OSPS_S_EXEC1: next_state = two_cycle ? `OSPS_S_EXEC2 : `OSPS_S_IDLE;
            `OSPS_S_EXEC2: next_state = `OSPS_S_IDLE;
            `OSPS_S_WAITBUS:
            begin
               if (bus_free)
                  next_state = d_dummy ? `OSPS_S_DUMMY1 : `OSPS_S_EXEC1;
            end
            `OSPS_S_DUMMY1: next_state = `OSPS_S_DUMMY2;
            `OSPS_S_DUMMY2: next_state = `OSPS_S_EXEC1;
            default: next_state = `OSPS_S_IDLE;
         endcase
      end
   end

   wire launch = late_end && (next_state == `OSPS_S_EXEC1);

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= `OSPS_S_IDLE;
         q_cls <= `OSPS_CLS_NONE;
         q_store <= 1'b0;
         q_a_mem <= 1'b0;
         q_a_ext <= 1'b0;
         q_b_mem <= 1'b0;
         q_b_ext <= 1'b0;
         last_single <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (take)
         begin
            q_cls <= in_cls;
            q_store <= in_store;
            q_a_mem <= d_a_mem;
            q_a_ext <= in_a_ext;
            q_b_mem <= d_b_mem;
            q_b_ext <= in_b_ext;
         end
         if (launch)
            last_single <= d_single;
      end
   end

   // ----------------------------------------------------------------
   // external store engine, one bus cycle per machine cycle
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_cnt <= `OSPS_ST_NONE;
         st_sel <= `OSPS_SEL_FIRST;
         st_gap <= 1'b0;
         st_two <= 1'b0;
      end
      else if (launch && d_st_cnt != `OSPS_ST_NONE)
      begin
         st_cnt <= d_st_cnt;
         st_sel <= d_st_sel;
         st_gap <= d_st_gap;
         st_two <= d_st_two;
      end
      else if (late_end)
      begin
         if (st_gap)
            st_gap <= 1'b0;
         else if (st_cnt != `OSPS_ST_NONE)
            st_cnt <= st_cnt - 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // per-cycle access plan
   // ----------------------------------------------------------------
   reg ie_en;
   reg ie_sel;
   reg il_en;
   reg il_sel;
   reg xr_en;
   reg xr_sel;
   reg we_en;
   reg wl_en;
   reg we_sel;
   reg dummy;

   always @*
   begin
      ie_en = 1'b0;
      ie_sel = `OSPS_SEL_FIRST;
      il_en = 1'b0;
      il_sel = `OSPS_SEL_FIRST;
      xr_en = 1'b0;
      xr_sel = `OSPS_SEL_FIRST;
      we_en = 1'b0;
      we_sel = `OSPS_SEL_FIRST;
      wl_en = 1'b0;
      dummy = 1'b0;
      case (state)
         `OSPS_S_DUMMY1, `OSPS_S_DUMMY2:
         begin
            xr_en = 1'b1;
            xr_sel = `OSPS_SEL_SECOND;
            dummy = 1'b1;
         end
         `OSPS_S_EXEC1:
         begin
            case (q_cls)
               `OSPS_CLS_TWO:
               begin
                  if (q_a_mem && !q_store)
                  begin
                     xr_en = q_a_ext;
                     il_en = !q_a_ext;
                  end
                  else if (q_a_mem)
                     we_en = !q_a_ext;
               end
               `OSPS_CLS_TRI, `OSPS_CLS_PMA:
               begin
                  if (q_pair && !q_a_ext)
                  begin
                     ie_en = 1'b1;
                     xr_en = q_b_ext;
                     xr_sel = `OSPS_SEL_SECOND;
                     il_en = !q_b_ext;
                     il_sel = `OSPS_SEL_SECOND;
                  end
                  else if (q_pair && (q_b_ext || q_cls == `OSPS_CLS_TRI))
                     xr_en = 1'b1;
                  else if (q_pair)
                  begin
                     il_en = 1'b1;
                     il_sel = `OSPS_SEL_SECOND;
                  end
                  else if (q_a_mem || q_b_mem)
                  begin
                     xr_sel = q_b_mem;
                     il_sel = q_b_mem;
                     xr_en = q_b_mem ? q_b_ext : q_a_ext;
                     il_en = !(q_b_mem ? q_b_ext : q_a_ext);
                  end
               end
               `OSPS_CLS_PST:
               begin
                  xr_en = q_a_mem && q_a_ext;
                  il_en = q_a_mem && !q_a_ext;
                  we_en = !q_b_ext;
                  we_sel = `OSPS_SEL_SECOND;
               end
               `OSPS_CLS_PDS:
               begin
                  we_en = !q_a_ext;
                  wl_en = !q_b_ext;
               end
               default:
               begin
                  we_en = 1'b0;
               end
            endcase
         end
         `OSPS_S_EXEC2:
         begin
            if (q_b_ext)
            begin
               xr_en = 1'b1;
               xr_sel = `OSPS_SEL_SECOND;
            end
            else if (q_cls == `OSPS_CLS_TRI)
            begin
               il_en = 1'b1;
               il_sel = `OSPS_SEL_SECOND;
            end
            else
               xr_en = 1'b1;
         end
         default:
         begin
            dummy = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // outputs; internal accesses, read latch and post phase-qualified
   // ----------------------------------------------------------------
   assign int_rd_en = (ie_en && early_phase) || (il_en && late_phase);
   assign int_rd_sel = early_phase ? ie_sel : il_sel;
   assign int_wr_en = (we_en && early_phase) || (wl_en && late_phase);
   assign int_wr_sel = early_phase ? we_sel : `OSPS_SEL_SECOND;
   assign ext_rd_en = xr_en;
   assign ext_rd_sel = xr_sel;
   assign ext_rd_dummy = dummy;
   assign ext_rd_latch = xr_en && !dummy && late_end;
   assign ext_wr_en = (st_cnt != `OSPS_ST_NONE) && !st_gap;
   assign ext_wr_sel = st_two ? (st_cnt <= `OSPS_ST_HALF) : st_sel;
   assign ext_post = st_gap && (st_cnt != `OSPS_ST_NONE) && late_phase;
   assign primary_bus_strobe = ext_rd_en || ext_wr_en;
endmodule

// ===== bench/osps_sched_sva.sv
// concurrent checks on the operand access phase scheduler ports
`timescale 1ns/1ps
module osps_sched_chk
#(
   parameter PHASE_CYC = 3
)
(
   input wire clk, // core clock
   input wire rst_n, // async reset, active low
   input wire in_ready, // instruction can be taken
   input wire pipe_hold, // later stages held
   input wire op_done, // instruction finished
   input wire early_phase, // early minor phase
   input wire late_phase, // late minor phase
   input wire int_rd_en, // internal read
   input wire int_rd_sel, // internal read operand
   input wire int_wr_en, // internal store
   input wire int_wr_sel, // internal store destination
   input wire ext_rd_en, // external read cycle
   input wire ext_rd_dummy, // dummy read
   input wire ext_rd_latch, // read data latched
   input wire ext_wr_en, // external store cycle
   input wire ext_post, // value posted to port
   input wire primary_bus_strobe // bus cycle active
);
   reg [7:0] late_run;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // helper: length of the current late phase
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         late_run <= 8'h00;
      else if (late_phase)
         late_run <= late_run + 8'h01;
      else
         late_run <= 8'h00;
   end

   sequence rd_cycle;
      ext_rd_en [*6];
   endsequence
   sequence late_end;
      late_phase ##1 early_phase;
   endsequence
   sequence post_end;
      ext_post ##1 !ext_post;
   endsequence

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   phase_excl_a: assert property (early_phase != late_phase)
      else $error("phase outputs not exclusive");
   late_len_a: assert property ($fell(late_phase) |-> late_run == PHASE_CYC)
      else $error("late phase of wrong length");
   done_end_a: assert property (op_done |-> late_phase ##1 (early_phase && !op_done))
      else $error("done not a pulse at late phase end");
   latch_end_a: assert property (ext_rd_latch |-> (ext_rd_en && !ext_rd_dummy) ##0 late_end)
      else $error("read latch outside late phase end");
   rd_start_a: assert property ($rose(ext_rd_en) |-> $rose(early_phase) ##0 rd_cycle)
      else $error("external read not a whole cycle from early start");
   wr_start_a: assert property ($rose(ext_wr_en) |-> $rose(early_phase))
      else $error("external store not started at early phase");
   late_store_a: assert property (int_wr_en && late_phase |-> int_wr_sel)
      else $error("late internal store not second destination");
   early_read_a: assert property (int_rd_en && early_phase |-> !int_rd_sel)
      else $error("early internal read not first operand");
   dummy_latch_a: assert property (ext_rd_dummy |-> ext_rd_en && !ext_rd_latch)
      else $error("dummy read latched or off the bus");
   post_late_a: assert property (ext_post |-> late_phase)
      else $error("posting outside late phase");
   post_store_a: assert property (post_end |-> ##[0:12] ext_wr_en)
      else $error("posted value never stored");
   hold_ready_a: assert property (pipe_hold |-> !in_ready)
      else $error("ready while holding");
   strobe_or_a: assert property (primary_bus_strobe == (ext_rd_en || ext_wr_en))
      else $error("bus strobe mismatch");
endmodule

bind osps_operand_phase_sched osps_sched_chk #(.PHASE_CYC(PHASE_CYC)) u_osps_sched_chk (.clk,
   .rst_n, .in_ready, .pipe_hold, .op_done, .early_phase, .late_phase, .int_rd_en,
   .int_rd_sel, .int_wr_en, .int_wr_sel, .ext_rd_en, .ext_rd_dummy, .ext_rd_latch,
   .ext_wr_en, .ext_post, .primary_bus_strobe);

// ===== bench/osps_ext_mem_model.sv
// external memory model on the primary bus: tallies read, dummy and store clocks
`timescale 1ns/1ps
module osps_ext_mem_model
(
   input wire clk, // core clock
   input wire rst_n, // async reset, active low
   input wire ext_rd_en, // read bus cycle
   input wire ext_rd_dummy, // read is a dummy
   input wire ext_wr_en, // store bus cycle
   output int rd_clks, // clocks of real reads
   output int dm_clks, // clocks of dummy reads
   output int wr_clks // clocks of stores
);
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_clks <= 0;
         dm_clks <= 0;
         wr_clks <= 0;
      end
      else
      begin
         // a dummy read strobes the device like a real one, so a fifo would advance
         if (ext_rd_en && ext_rd_dummy)
            dm_clks <= dm_clks + 1;
         if (ext_rd_en && !ext_rd_dummy)
            rd_clks <= rd_clks + 1;
         if (ext_wr_en)
            wr_clks <= wr_clks + 1;
      end
   end
endmodule

// ===== bench/osps_operand_phase_sched_tb_top.sv
// self-checking bench for the operand access phase scheduler
`timescale 1ns/1ps
module osps_operand_phase_sched_tb_top;
   localparam PH = 3;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic in_valid = 1'b0;
   logic [2:0] in_op_top = 3'h0;
   logic in_dual_store = 1'b0;
   logic in_store = 1'b0;
   logic in_a_mem = 1'b0;
   logic in_a_ext = 1'b0;
   logic in_b_mem = 1'b0;
   logic in_b_ext = 1'b0;
   wire in_ready, pipe_hold, op_done, early_phase, late_phase, int_rd_en, int_rd_sel;
   wire int_wr_en, int_wr_sel, ext_rd_en, ext_rd_sel, ext_rd_dummy, ext_rd_latch;
   wire ext_wr_en, ext_wr_sel, ext_post, primary_bus_strobe;
   int rd_clks, dm_clks, wr_clks;
   int n_errors = 0;
   int checked = 0;
   int n_take = 0;
   int lcnt = 0, cyc = 0, ird = 0, lat = 0, iwr = 0, iws = 0, xrs = 0;
   logic prev_single = 1'b0;
   logic le;
   logic [23:0] notes[$];
   // row: stimulus byte, cpu cycles, int read phases, int store phases, latches, store bus cycles
   logic [27:0] tbl [18] = '{
      28'h2811000, 28'h2c10010, 28'h2a12000, 28'h2b11010, 28'h2e21010, 28'h2f20020,
      28'h8a12000, 28'h8b11010, 28'h8e21010, 28'h8f20020, 28'hda10200, 28'hde10102,
      28'hdb10102, 28'hdf10004, 28'hca11100, 28'hcf10012, 28'hcb11002, 28'h1c10002};

   osps_operand_phase_sched #(.PHASE_CYC(PH)) u_osps_operand_phase_sched (.clk, .rst_n,
      .in_valid, .in_op_top, .in_dual_store, .in_store, .in_a_mem, .in_a_ext, .in_b_mem,
      .in_b_ext, .in_ready, .pipe_hold, .op_done, .early_phase, .late_phase, .int_rd_en,
      .int_rd_sel, .int_wr_en, .int_wr_sel, .ext_rd_en, .ext_rd_sel, .ext_rd_dummy,
      .ext_rd_latch, .ext_wr_en, .ext_wr_sel, .ext_post, .primary_bus_strobe);
   osps_ext_mem_model u_osps_ext_mem_model (.clk, .rst_n, .ext_rd_en, .ext_rd_dummy,
      .ext_wr_en, .rd_clks, .dm_clks, .wr_clks);

   initial
   begin
      forever #5 clk = ~clk;
   end

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // monitor: per instruction cycles, internal reads and latches
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      le = late_phase && lcnt == PH - 1;
      lcnt = late_phase ? lcnt + 1 : 0;
      if (int_rd_en) ird++;
      if (int_wr_en) iwr++;
      if (ext_wr_en && ext_wr_sel) iws++;
      if (ext_rd_en && ext_rd_sel && !ext_rd_dummy) xrs++;
      if (ext_rd_latch) lat++;
      if (le) cyc++;
      if (op_done && notes.size() == 0)
         cmp("spare done", 32'h0, 32'h1);
      else if (op_done)
         cmp("op result", notes.pop_front(), {cyc[7:0], ird[7:0], lat[7:0]});
      if (le && in_valid && in_ready)
      begin
         n_take++;
         cyc = 0;
         ird = 0;
         lat = 0;
      end
   end

   // ----------------------------------------------------------------
   // drivers
   // ----------------------------------------------------------------
   task automatic issue(input logic [27:0] r, input logic [7:0] ncyc);
      int t0;
      int k;
      notes.push_back({ncyc, 8'(r[15:12] * PH), 4'h0, r[7:4]});
      @(negedge clk);
      {in_op_top, in_dual_store, in_a_mem, in_a_ext, in_b_mem, in_b_ext} = r[27:20];
      in_store = r[24];
      in_valid = 1'b1;
      t0 = n_take;
      for (k = 0; k < 100 && n_take == t0; k++)
         @(posedge clk) #1;
      if (n_take == t0)
      begin
         n_errors++;
         conclude();
      end
   endtask

   task automatic drain();
      int q;
      int k;
      @(negedge clk);
      in_valid = 1'b0;
      q = 0;
      for (k = 0; k < 400 && q < 4 * PH; k++)
      begin
         @(negedge clk);
         q = (notes.size() == 0 && !primary_bus_strobe && !ext_post && !pipe_hold) ? q + 1 : 0;
      end
      if (q < 4 * PH)
      begin
         n_errors++;
         conclude();
      end
   endtask

   task automatic one(input logic [27:0] r);
      int w0;
      int i0;
      int r0;
      int s0;
      int x0;
      int d0;
      int es;
      int ex;
      logic dum;
      w0 = wr_clks;
      i0 = iwr;
      r0 = rd_clks;
      s0 = iws;
      x0 = xrs;
      d0 = dm_clks;
      // three-operand external second source read right after a single external store draws a dummy read
      dum = prev_single && r[27:25] == 3'h1 && r[21] && r[20];
      prev_single = (!r[27] && !r[25] && r[24] && r[23] && r[22])
                    || (r[27:26] == 2'h3 && !r[24] && r[21] && r[20]);
      es = (r[27:26] == 2'h3 && r[21] && r[20]) ? 2 * 2 * PH : 0;
      ex = (r[27:26] != 2'h3 && r[21] && r[20]) ? 2 * PH : 0;
      issue(r, r[19:16] + (dum ? 4'h2 : 4'h0));
      drain();
      cmp("dummy clocks", dum ? 2 * 2 * PH : 0, dm_clks - d0);
      cmp("second dest store clocks", es, iws - s0);
      cmp("second source read clocks", ex, xrs - x0);
      cmp("int store clocks", r[11:8] * PH, iwr - i0);
      cmp("ext store clocks", r[3:0] * 2 * PH, wr_clks - w0);
      cmp("ext read clocks", r[7:4] * 2 * PH, rd_clks - r0);
      $display("test %h done", r[27:20]);
   endtask

   initial
   begin
      int i;
      int w0;
      int d0;
      int r0;
      void'($urandom(17081));
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (i = 0; i < 36; i++)
         one(tbl[i < 18 ? i : $urandom % 18]);
      w0 = wr_clks;
      d0 = dm_clks;
      r0 = rd_clks;
      issue(28'h5c10002, 8'h1);
      issue(28'h2b11010, 8'h4);
      drain();
      cmp("dummy clocks", 2 * 2 * PH, dm_clks - d0);
      cmp("ext store clocks", 2 * 2 * PH, wr_clks - w0);
      cmp("ext read clocks", 2 * PH, rd_clks - r0);
      $display("test dummy read done");
      conclude();
   end
endmodule
